// ==== design/mps_regs.svh ====
// register map, field positions and reset values of the serdes pcs status bank
// assumes: included by every design file and bench file that decodes registers
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH

// ****************************************
// register numbers
// ****************************************
`define MPS_OFF_STD_LAST 5'h0f
`define MPS_OFF_EXT_LAST 5'h1e
`define MPS_OFF_PAGE     5'h1f
`define MPS_OFF_CTRL     5'h10
`define MPS_OFF_STAT     5'h11
`define MPS_OFF_ADV      5'h12
`define MPS_OFF_LP       5'h13
`define MPS_OFF_SDS      5'h14

// ****************************************
// page codes
// ****************************************
`define MPS_PAGE_MAIN 16'h0000
`define MPS_PAGE_EXT3 16'h0003

// ****************************************
// reset values
// ****************************************
`define MPS_RST_PAGE 16'h0000
`define MPS_RST_CTRL 16'h0100
`define MPS_RST_ADV  16'h0000
`define MPS_RST_LP   16'h0000

// ****************************************
// control register fields
// ****************************************
`define MPS_CTRL_RW_HI   15
`define MPS_CTRL_RW_LO   5
`define MPS_CTRL_RESTART 12
`define MPS_CTRL_FORCE   11
`define MPS_CTRL_AN_EN   7

// ****************************************
// status register fields
// ****************************************
`define MPS_ST_LP_RST  11
`define MPS_ST_RF_HI   9
`define MPS_ST_RF_LO   8
`define MPS_ST_ASYM    7
`define MPS_ST_SYM     6
`define MPS_ST_FD      5
`define MPS_ST_HD      4
`define MPS_ST_LP_AN   3
`define MPS_ST_LINK    2
`define MPS_ST_AN_DONE 1
`define MPS_ST_SIG     0
`define MPS_SDS_SIG    14
`define MPS_SDS_SYNC   13

// ****************************************
// code word fields of the received word
// ****************************************
`define MPS_CW_RF_HI 13
`define MPS_CW_RF_LO 12
`define MPS_CW_ASYM  8
`define MPS_CW_SYM   7
`define MPS_CW_HD    6
`define MPS_CW_FD    5

`endif

// ==== design/mps_pkg.sv ====
// types shared by the serdes pcs status bank
// assumes: compiled before every design module
package mps_pkg;
  typedef logic [15:0] mps_word_type;
  typedef logic [4:0]  mps_addr_type;
  typedef enum logic [1:0] {
    MPS_SPACE_MAIN,
    MPS_SPACE_EXT3,
    MPS_SPACE_OTHER
  } mps_space_type;
endpackage

// ==== design/mps_sticky.sv ====
// one sticky flag, set by hardware and cleared by a read
// assumes: set and clear are synchronous one-cycle or level signals
`timescale 1ns/1ps
module mps_sticky (
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  // set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= set_i | (flag_o & ~clr_i);
    end
  end
endmodule

// ==== design/mps_page_decode.sv ====
// page select register and address space decode
// assumes: register bus strobes are single cycle and synchronous
`timescale 1ns/1ps
`include "mps_regs.svh"
module mps_page_decode
  import mps_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          arst_n_i,
  input  wire logic          wr_i,
  input  wire mps_addr_type  addr_i,
  input  wire mps_word_type  wdata_i,
  output mps_word_type       page_o,
  output mps_space_type      space_o,
  output logic               ext_hit_o
);
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      page_o <= `MPS_RST_PAGE;
    end else if (wr_i && addr_i == `MPS_OFF_PAGE) begin
      page_o <= wdata_i;
    end
  end

  always_comb begin
    unique case (page_o)
      `MPS_PAGE_MAIN: space_o = MPS_SPACE_MAIN;
      `MPS_PAGE_EXT3: space_o = MPS_SPACE_EXT3;
      default:        space_o = MPS_SPACE_OTHER;
    endcase
  end

  // low registers never follow the page
  assign ext_hit_o = (space_o == MPS_SPACE_EXT3) && (addr_i > `MPS_OFF_STD_LAST) &&
                     (addr_i <= `MPS_OFF_EXT_LAST);
endmodule

// ==== design/mps_top.sv ====
// paged status and ability registers of the mac-side serdes pcs
// assumes: link status inputs are synchronous to core_clk_i; the standard
// registers 0..15 live in another block and read as zero here
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "mps_regs.svh"

module mps_top
  import mps_pkg::*;
#(
  parameter mps_word_type DEF_ABILITY = 16'h0001
) (
  input  wire logic          core_clk_i,
  input  wire logic          arst_n_i,
  input  wire mps_addr_type  reg_addr_i,
  input  wire mps_word_type  reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output mps_word_type       reg_rdata_o,
  input  wire logic          pcs_sig_det_i,
  input  wire logic          pcs_sync_i,
  input  wire logic          pcs_link_up_i,
  input  wire logic          pcs_an_done_i,
  input  wire logic          pcs_lp_an_able_i,
  input  wire logic          pcs_lp_restart_i,
  input  wire logic          rx_cfg_valid_i,
  input  wire mps_word_type  rx_cfg_word_i,
  output mps_word_type       tx_cfg_word_o,
  output logic               an_enable_o,
  output logic               an_restart_o,
  output logic               ext_page_o,
  output mps_word_type       ctrl_o
);

  // ****************************************
  // page select and decode
  // ****************************************
  mps_word_type  page;
  mps_space_type space;
  logic          ext_hit;

  mps_page_decode u_page (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .wr_i       (reg_wr_i),
    .addr_i     (reg_addr_i),
    .wdata_i    (reg_wdata_i),
    .page_o     (page),
    .space_o    (space),
    .ext_hit_o  (ext_hit)
  );

  logic wr_ctrl;
  logic wr_adv;
  logic rd_stat;
  logic rd_sds;

  // page 3 only claims 16..30 while the page holds 0x0003
  assign wr_ctrl = reg_wr_i && ext_hit && reg_addr_i == `MPS_OFF_CTRL;
  assign wr_adv  = reg_wr_i && ext_hit && reg_addr_i == `MPS_OFF_ADV;
  assign rd_stat = reg_rd_i && ext_hit && reg_addr_i == `MPS_OFF_STAT;
  assign rd_sds  = reg_rd_i && ext_hit && reg_addr_i == `MPS_OFF_SDS;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_page_o <= 1'b0;
    end else begin
      ext_page_o <= (page == `MPS_PAGE_EXT3);
    end
  end

  // ****************************************
  // pcs control register
  // ****************************************
  mps_word_type ctrl;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= `MPS_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl[`MPS_CTRL_RW_HI:`MPS_CTRL_RW_LO] <= reg_wdata_i[`MPS_CTRL_RW_HI:`MPS_CTRL_RW_LO];
    end else begin
      // restart request clears itself after one cycle
      ctrl[`MPS_CTRL_RESTART] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_o       <= `MPS_RST_CTRL;
      an_enable_o  <= 1'b0;
      an_restart_o <= 1'b0;
    end else begin
      ctrl_o       <= ctrl;
      an_enable_o  <= ctrl[`MPS_CTRL_AN_EN];
      an_restart_o <= ctrl[`MPS_CTRL_RESTART];
    end
  end

  // ****************************************
  // advertised and partner code words
  // ****************************************
  mps_word_type adv;
  mps_word_type lp_word;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      adv <= `MPS_RST_ADV;
    end else if (wr_adv && ctrl[`MPS_CTRL_FORCE]) begin
      adv <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_cfg_word_o <= DEF_ABILITY;
    end else begin
      tx_cfg_word_o <= ctrl[`MPS_CTRL_FORCE] ? adv : DEF_ABILITY;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lp_word <= `MPS_RST_LP;
    end else if (rx_cfg_valid_i) begin
      lp_word <= rx_cfg_word_i;
    end
  end

  // ****************************************
  // sticky flags
  // ****************************************
  logic lp_rst_flag;
  logic sig_flag;

  // restart request stays visible until software reads the status word
  mps_sticky u_lp_rst (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .set_i      (pcs_lp_restart_i),
    .clr_i      (rd_stat),
    .flag_o     (lp_rst_flag)
  );

  mps_sticky u_sig (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .set_i      (pcs_sig_det_i),
    .clr_i      (rd_sds),
    .flag_o     (sig_flag)
  );

  // ****************************************
  // status words
  // ****************************************
  mps_word_type stat_word;
  mps_word_type sds_word;

  always_comb begin
    stat_word                             = '0;
    stat_word[`MPS_ST_LP_RST]             = lp_rst_flag;
    stat_word[`MPS_ST_RF_HI:`MPS_ST_RF_LO] = lp_word[`MPS_CW_RF_HI:`MPS_CW_RF_LO];
    stat_word[`MPS_ST_ASYM]               = lp_word[`MPS_CW_ASYM];
    stat_word[`MPS_ST_SYM]                = lp_word[`MPS_CW_SYM];
    stat_word[`MPS_ST_FD]                 = lp_word[`MPS_CW_FD];
    stat_word[`MPS_ST_HD]                 = lp_word[`MPS_CW_HD];
    stat_word[`MPS_ST_LP_AN]              = pcs_lp_an_able_i;
    stat_word[`MPS_ST_LINK]               = pcs_link_up_i;
    stat_word[`MPS_ST_AN_DONE]            = pcs_an_done_i;
    stat_word[`MPS_ST_SIG]                = pcs_sig_det_i;
  end

  always_comb begin
    sds_word                = '0;
    sds_word[`MPS_SDS_SIG]  = sig_flag;
    sds_word[`MPS_SDS_SYNC] = pcs_sync_i;
  end

  // ****************************************
  // read data
  // ****************************************
  mps_word_type next_rdata;

  // the standard space belongs to another block, so 0..15 read zero here
  always_comb begin
    next_rdata = '0;
    if (reg_addr_i == `MPS_OFF_PAGE) begin
      next_rdata = page;
    end else if (ext_hit) begin
      unique case (reg_addr_i)
        `MPS_OFF_CTRL: next_rdata = {ctrl[15:5], 5'h00};
        `MPS_OFF_STAT: next_rdata = stat_word;
        `MPS_OFF_ADV:  next_rdata = adv;
        `MPS_OFF_LP:   next_rdata = lp_word;
        `MPS_OFF_SDS:  next_rdata = sds_word;
        default:       next_rdata = '0;
      endcase
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence page3_wr_s;
    reg_wr_i && reg_addr_i == 5'h1f && reg_wdata_i == 16'h0003;
  endsequence

  sequence main_wr_s;
    reg_wr_i && reg_addr_i == 5'h1f && reg_wdata_i == 16'h0000;
  endsequence

  sequence sig_seen_s;
    pcs_sig_det_i ##1 !rd_sds [*2];
  endsequence

  page_select_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    page3_wr_s |-> ##2 ext_page_o)
    else $error("page 3 not selected after write of 3");

  main_return_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    main_wr_s |-> ##1 !ext_hit ##1 !ext_page_o)
    else $error("main page not restored after write of 0");

  std_space_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (reg_rd_i && reg_addr_i <= 5'h0f) |=> reg_rdata_o == 16'h0000)
    else $error("standard register answered from page bank");

  adv_lock_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (wr_adv && !ctrl[11]) |=> $stable(adv))
    else $error("advertised word changed without force bit");

  tx_force_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ctrl[11] |=> tx_cfg_word_o == $past(adv))
    else $error("forced advertised word not transmitted");

  lp_capture_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rx_cfg_valid_i |=> lp_word == $past(rx_cfg_word_i))
    else $error("partner word not captured");

  sig_latch_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    sig_seen_s |-> sig_flag)
    else $error("signal detect flag not held");

  sig_clear_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (rd_sds && !pcs_sig_det_i) |=> !sig_flag ##0 reg_rdata_o[14] == $past(sig_flag))
    else $error("signal detect flag not cleared by read");

  link_read_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_stat |=> reg_rdata_o[2] == $past(pcs_link_up_i) && reg_rdata_o[15:12] == 4'h0)
    else $error("link status bit wrong");

  fault_read_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_stat |=> reg_rdata_o[9:8] == $past(lp_word[13:12]))
    else $error("remote fault field wrong");

  restart_seen_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (pcs_lp_restart_i ##1 rd_stat) |=> reg_rdata_o[11])
    else $error("partner restart request not reported");

  restart_clear_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (rd_stat && !pcs_lp_restart_i) |=> !lp_rst_flag)
    else $error("partner restart flag not cleared by read");

  pause_read_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_stat |=> reg_rdata_o[7:6] == $past(lp_word[8:7]))
    else $error("pause bits wrong");

  duplex_read_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_stat |=> reg_rdata_o[5] == $past(lp_word[5]) && reg_rdata_o[4] == $past(lp_word[6]))
    else $error("duplex bits wrong");

  able_read_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_stat |=> reg_rdata_o[3] == $past(pcs_lp_an_able_i))
    else $error("partner autoneg ability bit wrong");

  done_read_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_stat |=> reg_rdata_o[1] == $past(pcs_an_done_i))
    else $error("autoneg complete bit wrong");

  sig_read_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_stat |=> reg_rdata_o[0] == $past(pcs_sig_det_i))
    else $error("signal detect status bit wrong");

  sync_read_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_sds |=> reg_rdata_o[13] == $past(pcs_sync_i))
    else $error("receiver sync bit wrong");

  sds_reserved_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    rd_sds |=> reg_rdata_o[15] == 1'b0 && reg_rdata_o[12:0] == 13'h0000)
    else $error("reserved serdes status bits not zero");

  // a detect in the read cycle must survive the read-clear
  sig_priority_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (pcs_sig_det_i && rd_sds) |=> sig_flag)
    else $error("signal detect lost against read clear");

  tx_default_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !ctrl[11] |=> tx_cfg_word_o == DEF_ABILITY)
    else $error("default config word not transmitted");

  page_gate_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (reg_rd_i && page != 16'h0003 && reg_addr_i != 5'h1f) |=> reg_rdata_o == 16'h0000)
    else $error("page bank answered outside page 3");

  sequence adv_force_wr_s;
    wr_adv && ctrl[11];
  endsequence

  adv_write_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    adv_force_wr_s |=> adv == $past(reg_wdata_i))
    else $error("forced advertised word not written");

  rdata_idle_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read");

endmodule

// ==== test/mps_mac_model.sv ====
// behavioural mac at the far side of the serdes pcs: line state and config words
// assumes: driven from the bench by task calls; all changes land just after a rising edge
`timescale 1ns/1ps
module mps_mac_model
  import mps_pkg::*;
(
  input  wire logic   core_clk_i,
  output logic        sig_det_o,
  output logic        sync_o,
  output logic        link_up_o,
  output logic        an_done_o,
  output logic        lp_an_able_o,
  output logic        lp_restart_o,
  output logic        cfg_valid_o,
  output mps_word_type cfg_word_o
);
  initial begin
    {sig_det_o, sync_o, link_up_o, an_done_o, lp_an_able_o} = 5'h00;
    lp_restart_o = 1'b0;
    cfg_valid_o  = 1'b0;
    cfg_word_o   = 16'h0000;
  end

  // ****************************************
  // line state, order {sig, sync, link, done, able}
  // ****************************************
  task automatic set_line(input logic [4:0] v);
    @(posedge core_clk_i);
    {sig_det_o, sync_o, link_up_o, an_done_o, lp_an_able_o} <= v;
  endtask

  // ****************************************
  // events and config words
  // ****************************************
  task automatic send_cfg(input mps_word_type w);
    @(posedge core_clk_i);
    cfg_valid_o <= 1'b1;
    cfg_word_o  <= w;
    @(posedge core_clk_i);
    cfg_valid_o <= 1'b0;
    cfg_word_o  <= ~w; // bus no longer holds the word once valid drops
  endtask

  task automatic pulse_restart();
    @(posedge core_clk_i);
    lp_restart_o <= 1'b1;
    @(posedge core_clk_i);
    lp_restart_o <= 1'b0;
  endtask

  task automatic pulse_sig();
    @(posedge core_clk_i);
    sig_det_o <= 1'b1;
    @(posedge core_clk_i);
    sig_det_o <= 1'b0;
  endtask
endmodule

// ==== test/mps_top_tb.sv ====
// self-checking bench of the serdes pcs status bank over its register port
// assumes: the mac model drives every link input; one clock, async low reset
`timescale 1ns/1ps
`include "mps_regs.svh"
module mps_top_tb;
  import mps_pkg::*;
  localparam mps_word_type DEF_ABIL = 16'h0001;

  logic         core_clk;
  logic         arst_n;
  mps_addr_type reg_addr;
  mps_word_type reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  mps_word_type reg_rdata;
  logic         sig_det, sync, link_up, an_done, lp_an_able, lp_restart, cfg_valid;
  mps_word_type cfg_word, tx_cfg, ctrl;
  logic         an_enable, ext_page, an_restart;
  int           mismatches, check_count, cycles;
  mps_word_type rd_val, st_exp;
  mps_word_type words [2] = '{16'h31e0, 16'h2140};
  logic [4:0]   lines [2] = '{5'b11111, 5'b00110};

  mps_top #(.DEF_ABILITY(DEF_ABIL)) DUT (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .pcs_sig_det_i(sig_det),
    .pcs_sync_i(sync), .pcs_link_up_i(link_up), .pcs_an_done_i(an_done),
    .pcs_lp_an_able_i(lp_an_able), .pcs_lp_restart_i(lp_restart), .rx_cfg_valid_i(cfg_valid),
    .rx_cfg_word_i(cfg_word), .tx_cfg_word_o(tx_cfg), .an_enable_o(an_enable),
    .an_restart_o(an_restart), .ext_page_o(ext_page), .ctrl_o(ctrl));

  mps_mac_model mac (
    .core_clk_i(core_clk), .sig_det_o(sig_det), .sync_o(sync), .link_up_o(link_up),
    .an_done_o(an_done), .lp_an_able_o(lp_an_able), .lp_restart_o(lp_restart),
    .cfg_valid_o(cfg_valid), .cfg_word_o(cfg_word));

  // ****************************************
  // clock, reset, hang guard
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 3000) begin
      mismatches++;
      results();
    end
  end

  // ****************************************
  // register port tasks and comparison
  // ****************************************
  task automatic wr(input mps_addr_type a, input mps_word_type d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input mps_addr_type a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic check(input mps_word_type seen, input mps_word_type exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // status word expected from a received word and the line state
  function automatic mps_word_type status_of(input mps_word_type w, input logic [4:0] v);
    return {6'h00, w[13:12], w[8], w[7], w[5], w[6], v[0], v[2], v[1], v[4]};
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    arst_n = 1'b0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;

    rd(`MPS_OFF_STAT);
    check(rd_val, 16'h0000);
    check({15'h0, ext_page}, 16'h0000);
    check(tx_cfg, DEF_ABIL);
    check(ctrl, 16'h0100);
    $display("test reset done");

    wr(`MPS_OFF_PAGE, `MPS_PAGE_EXT3);
    repeat (2) @(posedge core_clk);
    #1 check({15'h0, ext_page}, 16'h0001);
    rd(5'h01);
    check(rd_val, 16'h0000);
    rd(`MPS_OFF_ADV);
    check(rd_val, 16'h0000);
    wr(`MPS_OFF_ADV, 16'hbeef);
    rd(`MPS_OFF_ADV);
    check(rd_val, 16'h0000);
    wr(`MPS_OFF_CTRL, 16'h0980);
    wr(`MPS_OFF_ADV, 16'hbeef);
    rd(`MPS_OFF_ADV);
    check(rd_val, 16'hbeef);
    check(tx_cfg, 16'hbeef);
    check(ctrl, 16'h0980);
    check({15'h0, an_enable}, 16'h0001);
    rd(`MPS_OFF_PAGE);
    check(rd_val, 16'h0003);
    wr(`MPS_OFF_CTRL, 16'h1980);
    @(posedge core_clk);
    #1 check({15'h0, an_restart}, 16'h0001);
    @(posedge core_clk);
    #1 check({15'h0, an_restart}, 16'h0000);
    rd(`MPS_OFF_CTRL);
    check(rd_val, 16'h0980);
    rd(5'h15);
    check(rd_val, 16'h0000);
    $display("test paging and advertised word done");

    for (int i = 0; i < 2; i++) begin
      mac.set_line(lines[i]);
      mac.send_cfg(words[i]);
      rd(`MPS_OFF_LP);
      check(rd_val, words[i]);
      rd(`MPS_OFF_STAT);
      check(rd_val, status_of(words[i], lines[i]));
    end
    st_exp = status_of(words[1], lines[1]);
    mac.pulse_restart();
    rd(`MPS_OFF_STAT);
    check(rd_val, st_exp | 16'h0800);
    rd(`MPS_OFF_STAT);
    check(rd_val, st_exp);
    $display("test status and partner word done");

    mac.set_line(5'b11110);
    rd(`MPS_OFF_SDS);
    check(rd_val, 16'h6000);
    rd(`MPS_OFF_SDS);
    check(rd_val, 16'h6000);
    mac.set_line(5'b01110);
    rd(`MPS_OFF_SDS);
    rd(`MPS_OFF_SDS);
    check(rd_val, 16'h2000);
    mac.pulse_sig();
    rd(`MPS_OFF_SDS);
    check(rd_val, 16'h6000);
    rd(`MPS_OFF_SDS);
    check(rd_val, 16'h2000);
    wr(`MPS_OFF_SDS, 16'hffff);
    wr(`MPS_OFF_LP, 16'h1234);
    rd(`MPS_OFF_SDS);
    check(rd_val, 16'h2000);
    rd(`MPS_OFF_LP);
    check(rd_val, words[1]);
    $display("test sticky detect done");

    wr(`MPS_OFF_PAGE, `MPS_PAGE_MAIN);
    rd(`MPS_OFF_STAT);
    check(rd_val, 16'h0000);
    check({15'h0, ext_page}, 16'h0000);
    wr(`MPS_OFF_PAGE, 16'h0010);
    rd(`MPS_OFF_STAT);
    check(rd_val, 16'h0000);
    rd(`MPS_OFF_PAGE);
    check(rd_val, 16'h0010);
    $display("test main page done");
    results();
  end
endmodule
